// ### hbspi_pkg.sv
package hbspi_pkg;
  // ==========================================================================
  // Pin lanes and widths
  localparam int ADDR_W    = 10;
  localparam int DATA_W    = 8;
  localparam int MOSI_BIT  = 0;
  localparam int MISO_BIT  = 1;
  localparam int SCLK_BIT  = 2;
  localparam int SYNC_W    = 3 + ADDR_W + DATA_W;
  // ==========================================================================
  // Boot strap and serial framing
  localparam logic [1:0] MODE_SPI_MASTER = 2'h2;
  localparam int         HDR_BITS        = 24;
  localparam int         BYTE_W          = 8;
  localparam int         CNT_W           = 12;
  localparam logic [1:0] STRAP_WAIT      = 2'h2;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SCLK_PERIOD_NS = 80;
  localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  // ==========================================================================
  // Reset values
  localparam logic [SYNC_W-1:0] SYNC_RST = {3'h7, {(ADDR_W + DATA_W){1'b0}}};

  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_DONE} hbspi_state_e;
endpackage : hbspi_pkg

// ### hbspi_buf2.sv
`timescale 1ns/1ps
`default_nettype none
module hbspi_buf2 #(
  parameter int W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  logic [W-1:0] mem [2];
  logic         wr_ptr;
  logic         rd_ptr;
  logic [1:0]   count;
  logic         push;
  logic         pop;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      wr_ptr <= wr_ptr ^ push;
      rd_ptr <= rd_ptr ^ pop;
      count  <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : hbspi_buf2
`default_nettype wire

// ### hbspi_host_pins.sv
// Function
// - Ten-bit host address, pin 0 least significant.
// - Eight-bit bidirectional data lane, bit 0 LSB.
// - Data pins undriven in reset or when select high; serial boot drives data 0 and 2.
// - Serial boot sends instruction, address on data 0.
// - Output data changes on edge chosen by phase.
// - Input data sampled on opposite edge to change.
// - Device drives serial clock on data 2.
// - Dedicated active-low EEPROM select in master mode.
`timescale 1ns/1ps
`default_nettype none
module hbspi_host_pins
  import hbspi_pkg::*;
#(
  parameter int HALF = hbspi_pkg::SCLK_HALF_CYC
) (
  input  wire logic                          core_clk,
  input  wire logic                          nrst,
  input  wire logic                          hardware_mode_pin,
  input  wire logic [1:0]                    mode_control_pins,
  input  wire logic                          clock_phase_select,
  input  wire logic                          host_sel_n,
  input  wire logic                          host_rd_n,
  input  wire logic                          host_wr_n,
  input  wire logic [hbspi_pkg::ADDR_W-1:0]  host_addr_pin,
  input  wire logic [hbspi_pkg::DATA_W-1:0]  host_data_in,
  output logic      [hbspi_pkg::DATA_W-1:0]  host_data_out,
  output logic      [hbspi_pkg::DATA_W-1:0]  host_data_oe,
  output logic                               eeprom_sel_n,
  output logic                               spi_mode,
  output logic      [hbspi_pkg::ADDR_W-1:0]  reg_addr,
  output logic                               reg_wr,
  output logic      [hbspi_pkg::DATA_W-1:0]  reg_wr_data,
  input  wire logic [hbspi_pkg::DATA_W-1:0]  reg_rd_data,
  input  wire logic                          boot_valid,
  output logic                               boot_ready,
  input  wire logic [7:0]                    boot_instr,
  input  wire logic [15:0]                   boot_addr,
  input  wire logic [7:0]                    boot_len,
  output logic                               boot_busy,
  output logic                               rd_valid,
  input  wire logic                          rd_ready,
  output logic      [hbspi_pkg::DATA_W-1:0]  rd_data
);
  import hbspi_pkg::*;

  // ==========================================================================
  // Input synchronisers
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [3:0]        strap1;
  logic [3:0]        strap2;
  logic [1:0]        miso_sync;
  logic              sel_n_s;
  logic              rd_n_s;
  logic              wr_n_s;
  logic              wr_n_prev;
  logic              pha;
  logic              miso;

  always_ff @(posedge core_clk) begin
    strap1 <= {clock_phase_select, hardware_mode_pin, mode_control_pins};
    strap2 <= strap1;
    if (!nrst) begin
      sync1     <= SYNC_RST;
      sync2     <= SYNC_RST;
      miso_sync <= 2'h0;
    end else begin
      sync1     <= {host_sel_n, host_rd_n, host_wr_n, host_addr_pin, host_data_in};
      sync2     <= sync1;
      miso_sync <= {miso_sync[0], host_data_in[MISO_BIT]};
    end
  end

  assign sel_n_s = sync2[SYNC_W-1];
  assign rd_n_s  = sync2[SYNC_W-2];
  assign wr_n_s  = sync2[SYNC_W-3];
  assign miso    = miso_sync[1];
  assign pha     = strap2[3];

  // ==========================================================================
  // Boot strap capture
  // The mode straps are read once, a fixed delay after reset release, so that
  // pins later reused as data lanes cannot flip the mode mid-boot.
  logic [1:0] strap_cnt;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      strap_cnt <= 2'h0;
      spi_mode  <= 1'b0;
    end else begin
      if (strap_cnt != STRAP_WAIT) begin
        strap_cnt <= strap_cnt + 2'h1;
      end
      if (strap_cnt == STRAP_WAIT - 2'h1) begin
        spi_mode <= !strap2[2] && (strap2[1:0] == MODE_SPI_MASTER);
      end
    end
  end

  // ==========================================================================
  // Host register port
  logic host_rd_act;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      reg_addr      <= '0;
      reg_wr        <= 1'b0;
      reg_wr_data   <= '0;
      wr_n_prev     <= 1'b1;
    end else begin
      reg_addr      <= sync2[DATA_W +: ADDR_W];
      wr_n_prev     <= wr_n_s;
      // Writes commit on the rising edge of the write strobe.
      reg_wr        <= !spi_mode && !sel_n_s && !wr_n_prev && wr_n_s;
      reg_wr_data   <= sync2[DATA_W-1:0];
    end
  end

  assign host_rd_act = nrst && !spi_mode && !sel_n_s && !rd_n_s;

  // ==========================================================================
  // Serial master engine
  hbspi_state_e     state;
  logic [7:0]       div_cnt;
  logic             tick;
  logic             sclk;
  logic             mosi;
  logic [HDR_BITS-1:0] tx;
  logic [CNT_W-1:0] bit_cnt;
  logic [CNT_W-1:0] total;
  logic [BYTE_W-1:0] rx_sh;
  logic             pend;
  logic [BYTE_W-1:0] pend_data;
  logic             buf_ready;
  logic             rise;
  logic             fall;
  logic             samp;
  logic             start;
  logic             all_in;

  assign tick   = (state == ST_XFER) && (div_cnt == 8'(HALF - 1));
  assign all_in = (bit_cnt == total);
  // A pending byte holds the clock low, so a stalled reader never loses data.
  assign rise   = tick && !sclk && !pend && !all_in;
  assign fall   = tick && sclk;
  assign samp   = pha ? fall : rise;
  assign start  = boot_valid && boot_ready;
  assign boot_ready = nrst && spi_mode && (state == ST_IDLE);
  assign boot_busy  = (state != ST_IDLE);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state   <= ST_IDLE;
      div_cnt <= 8'h0;
      sclk    <= 1'b0;
      eeprom_sel_n <= 1'b1;
      total   <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            state        <= ST_XFER;
            eeprom_sel_n <= 1'b0;
            total        <= CNT_W'(HDR_BITS) + {boot_len, 3'h0};
            div_cnt      <= 8'h0;
          end
        end
        ST_XFER: begin
          div_cnt <= tick ? 8'h0 : div_cnt + 8'h1;
          if (rise || fall) begin
            sclk <= !sclk;
          end
          if (all_in && !sclk && !pend) begin
            state        <= ST_DONE;
            eeprom_sel_n <= 1'b1;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx   <= '0;
      mosi <= 1'b0;
    end else if (start) begin
      // Low phase needs the first bit ready before the first rising edge.
      tx   <= pha ? {boot_instr, boot_addr} : {boot_instr[6:0], boot_addr, 1'b0};
      mosi <= pha ? 1'b0 : boot_instr[7];
    end else if ((pha && rise) || (!pha && fall)) begin
      mosi <= tx[HDR_BITS-1];
      tx   <= {tx[HDR_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bit_cnt   <= '0;
      rx_sh     <= '0;
      pend      <= 1'b0;
      pend_data <= '0;
    end else begin
      if (start) begin
        bit_cnt <= '0;
      end else if (samp) begin
        bit_cnt <= bit_cnt + CNT_W'(1);
        rx_sh   <= {rx_sh[BYTE_W-2:0], miso};
      end
      if (pend && buf_ready) begin
        pend <= 1'b0;
      end
      if (samp && (bit_cnt >= CNT_W'(HDR_BITS)) && (bit_cnt[2:0] == 3'h7)) begin
        pend      <= 1'b1;
        pend_data <= {rx_sh[BYTE_W-2:0], miso};
      end
    end
  end

  hbspi_buf2 #(
    .W (BYTE_W)
  ) u_buf (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_valid  (pend),
    .in_ready  (buf_ready),
    .in_data   (pend_data),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  // ==========================================================================
  // Pin drive
  always_comb begin
    host_data_oe = {DATA_W{host_rd_act}};
    if (nrst && spi_mode) begin
      host_data_oe           = '0;
      host_data_oe[MOSI_BIT] = 1'b1;
      host_data_oe[SCLK_BIT] = 1'b1;
    end
  end

  // Read data loads only during a read, so boot mode starts with idle serial lanes.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      host_data_out <= '0;
    end else if (spi_mode) begin
      host_data_out[MOSI_BIT] <= mosi;
      host_data_out[SCLK_BIT] <= sclk;
    end else if (host_rd_act) begin
      host_data_out <= reg_rd_data;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_shift;
    (pha && rise) || (!pha && fall);
  endsequence
  sequence s_sample;
    (pha && fall) || (!pha && rise);
  endsequence

  AST_ADDR_PIPE: assert property ($past(nrst, 3) |-> reg_addr == $past(host_addr_pin, 3))
    else $error("Register address does not follow the address pins.");
  AST_LANE_WIDE: assert property (!spi_mode && host_data_oe != 8'h00 |-> host_data_oe == 8'hff)
    else $error("Host read drives only part of the data lane.");
  AST_OE_SEL: assert property (!spi_mode && sel_n_s |-> host_data_oe == 8'h00)
    else $error("Data pins driven while host select is high.");
  AST_MOSI_SHIFT: assert property (s_shift |=> mosi == $past(tx[HDR_BITS-1]))
    else $error("Serial output does not carry the next header bit.");
  AST_MOSI_EDGE: assert property ($changed(mosi) && state == ST_XFER |-> $past(pha ? rise : fall))
    else $error("Serial output changed on the wrong clock edge.");
  AST_SAMPLE: assert property (s_sample |=> rx_sh[0] == $past(miso))
    else $error("Serial input not sampled on the phase edge.");
  AST_SCLK_IDLE: assert property (eeprom_sel_n |-> !sclk && (!spi_mode || host_data_oe[SCLK_BIT]))
    else $error("Serial clock active outside a transaction.");
  AST_SEL_HELD: assert property (start |=> !eeprom_sel_n [*2])
    else $error("EEPROM select not asserted at start.");
  AST_SEL_GAP: assert property (state == ST_DONE |-> eeprom_sel_n ##1 eeprom_sel_n)
    else $error("EEPROM select not released between transactions.");
  AST_NO_LOSS: assert property (pend && !buf_ready |=> pend && $stable(pend_data) && !rise)
    else $error("Received byte lost under stall.");
endmodule : hbspi_host_pins
`default_nettype wire

// ### hbspi_eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==============================
// Serial configuration memory on the far side of the link
module hbspi_eeprom_model (
  input  wire logic        sel_n,
  input  wire logic        sclk,
  input  wire logic        mosi,
  input  wire logic        pha,
  output logic             miso,
  output logic      [23:0] hdr
);
  int n = 0;

  initial begin
    miso = 1'b0;
    hdr = 24'h0;
  end

  // Contents follow the address, so the bench predicts every byte without a shared table.
  function automatic logic [7:0] mem(input int a);
    return 8'(a) ^ 8'ha5;
  endfunction : mem

  task automatic take();
    if (!sel_n && n < 24) hdr = {hdr[22:0], mosi};
    if (!sel_n) n++;
  endtask : take

  task automatic give();
    logic [7:0] b;
    int         k;
    k = n - 24;
    b = mem(hdr[15:0] + k / 8);
    if (!sel_n && k >= 0) miso = b[7 - k % 8];
  endtask : give

  always @(posedge sclk) begin
    if (pha) give();
    else take();
  end
  always @(negedge sclk) begin
    if (pha) take();
    else give();
  end
  always @(negedge sel_n) n = 0;
  // A released line does not keep its last level, so the model turns it over.
  always @(posedge sel_n) miso = ~miso;
endmodule : hbspi_eeprom_model
`default_nettype wire

// ### test_hbspi_host_pins.sv
`timescale 1ns/1ps
`default_nettype none
module test_hbspi_host_pins;
  import hbspi_pkg::*;
  // ==============================
  // Signals
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hardware_mode_pin = 1'b0;
  logic [1:0]  mode_control_pins = 2'h0;
  logic        clock_phase_select = 1'b1;
  logic        host_sel_n = 1'b1;
  logic        host_rd_n = 1'b1;
  logic        host_wr_n = 1'b1;
  logic [9:0]  host_addr_pin = 10'h0;
  logic [7:0]  drv = 8'h0;
  logic [7:0]  reg_rd_data = 8'h0;
  logic        boot_valid = 1'b0;
  logic [7:0]  boot_instr = 8'h0;
  logic [15:0] boot_addr = 16'h0;
  logic [7:0]  boot_len = 8'h0;
  logic        rd_ready = 1'b0;
  logic        boot = 1'b0;
  logic        stall = 1'b0;
  logic [15:0] lfsr = 16'h83af;
  logic        pm, pc, ps;
  logic [7:0]  host_data_out, host_data_oe, reg_wr_data, rd_data;
  logic [9:0]  reg_addr;
  logic        eeprom_sel_n, spi_mode, reg_wr, boot_ready, boot_busy, rd_valid, miso;
  logic [23:0] hdr;
  logic [7:0]  exp_q[$];
  int          mismatches = 0;
  int          compares = 0;
  wire logic [7:0] pins;

  // Bit one comes from the memory in serial boot; other undriven bits wander so stale never passes.
  assign pins = (host_data_oe & host_data_out)
              | (~host_data_oe & (boot ? {drv[7:2], miso, drv[0]} : drv));

  hbspi_host_pins i_dut (.core_clk(core_clk), .nrst(nrst),
    .hardware_mode_pin(hardware_mode_pin), .mode_control_pins(mode_control_pins),
    .clock_phase_select(clock_phase_select), .host_sel_n(host_sel_n),
    .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_addr_pin(host_addr_pin),
    .host_data_in(pins), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .eeprom_sel_n(eeprom_sel_n), .spi_mode(spi_mode), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .boot_valid(boot_valid), .boot_ready(boot_ready), .boot_instr(boot_instr),
    .boot_addr(boot_addr), .boot_len(boot_len), .boot_busy(boot_busy),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));

  hbspi_eeprom_model i_eeprom (.sel_n(eeprom_sel_n), .sclk(pins[2]), .mosi(pins[0]),
    .pha(clock_phase_select), .miso(miso), .hdr(hdr));

  always #5 core_clk = ~core_clk;

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt

  // ==============================
  // Checks
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk

  task automatic stop_test();
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  always @(posedge core_clk) begin
    lfsr <= nxt(lfsr);
    rd_ready <= !stall && (lfsr[0] || lfsr[5]);
    if (boot) drv <= lfsr[7:0];
    pm <= pins[0];
    pc <= pins[2];
    ps <= eeprom_sel_n;
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      chk("byte expected", 24'h1, 24'(exp_q.size() != 0));
      if (exp_q.size() != 0) chk("read byte", 24'(exp_q.pop_front()), 24'(rd_data));
    end
    if (boot && nrst && !eeprom_sel_n && !ps && pins[0] !== pm)
      chk("mosi edge", 24'({pc, clock_phase_select}), 24'({~pins[2], pins[2]}));
    if (boot && nrst && eeprom_sel_n === 1'b1 && host_data_oe[2] === 1'b1)
      chk("idle clock", 24'h0, 24'(pins[2]));
  end

  // ==============================
  // Stimulus
  task automatic rst(input logic hw, input logic [1:0] m);
    @(posedge core_clk);
    nrst <= 1'b0;
    hardware_mode_pin <= hw;
    mode_control_pins <= m;
    boot <= !hw && m == 2'h2;
    repeat (5) @(posedge core_clk);
    chk("oe in reset", 24'h0, 24'(host_data_oe));
    nrst <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk("boot mode", 24'(boot), 24'(spi_mode));
  endtask : rst

  task automatic hwr(input logic [9:0] a, input logic [7:0] d, input logic s);
    int n;
    n = 0;
    @(posedge core_clk);
    host_sel_n <= s;
    host_addr_pin <= a;
    if (!boot) drv <= d;
    host_wr_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    host_wr_n <= 1'b1;
    repeat (8) begin
      @(posedge core_clk);
      #1;
      if (reg_wr === 1'b1) begin
        n++;
        chk("write address", 24'(a), 24'(reg_addr));
        chk("write data", 24'(d), 24'(reg_wr_data));
      end
    end
    chk("write pulses", 24'(!s && !boot), 24'(n));
    @(posedge core_clk);
    host_sel_n <= 1'b1;
  endtask : hwr

  task automatic hrd(input logic [7:0] d);
    @(posedge core_clk);
    host_sel_n <= 1'b0;
    host_rd_n <= 1'b0;
    reg_rd_data <= d;
    repeat (5) @(posedge core_clk);
    #1;
    chk("read drive", 24'hff, 24'(host_data_oe));
    chk("read data", 24'(d), 24'(host_data_out));
    @(posedge core_clk);
    host_sel_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    chk("deselected drive", 24'h0, 24'(host_data_oe));
    @(posedge core_clk);
    host_rd_n <= 1'b1;
  endtask : hrd

  task automatic xfer(input logic p, input logic [7:0] len, input int hold);
    int          t;
    logic [15:0] a;
    a = lfsr;
    @(posedge core_clk);
    clock_phase_select <= p;
    repeat (2) @(posedge core_clk);
    boot_valid <= 1'b1;
    boot_instr <= 8'h03;
    boot_addr <= a;
    boot_len <= len;
    stall <= hold != 0;
    for (t = 0; t < len; t++) exp_q.push_back(8'(a + 16'(t)) ^ 8'ha5);
    @(posedge core_clk);
    while (boot_ready !== 1'b1) @(posedge core_clk);
    boot_valid <= 1'b0;
    repeat (hold + 2) @(posedge core_clk);
    if (hold != 0) begin
      t = 0;
      repeat (40) begin
        @(posedge core_clk);
        t += int'(pins[2]);
      end
      chk("stalled link", 24'h0, 24'(t) | 24'(eeprom_sel_n));
      stall <= 1'b0;
    end
    t = 0;
    while ((boot_busy !== 1'b0 || exp_q.size() != 0) && t < 4000) begin
      @(posedge core_clk);
      t++;
    end
    #1;
    chk("header", {8'h03, a}, hdr);
    chk("bytes left", 24'h0, 24'(exp_q.size()));
    chk("deselect", 24'h1, 24'(eeprom_sel_n));
  endtask : xfer

  initial begin
    rst(1'b1, 2'h2);
    rst(1'b0, 2'h0);
    for (int i = 0; i < 4; i++) begin
      hwr(i == 0 ? 10'h3ff : lfsr[9:0], lfsr[15:8], 1'b0);
      hrd(lfsr[7:0]);
    end
    hwr(10'h155, 8'h5a, 1'b1);
    rst(1'b0, 2'h2);
    hwr(10'h2aa, 8'ha5, 1'b0);
    xfer(1'b1, 8'h3, 0);
    xfer(1'b0, 8'h0, 0);
    xfer(1'b0, 8'h5, 700);
    xfer(1'b1, 8'h1, 0);
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    stop_test();
  end
endmodule : test_hbspi_host_pins
`default_nettype wire
